// ===== hw/rsc_delay_counter.sv
// delay counter stretching the internal reset
// assumes timeout_cycles is at least one and steady while counting
module rsc_delay_counter
	import rsc_pkg::*;
#(
	parameter int CNT_W = DLY_CNT_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// link to controller
	rsc_dly_if.dly dl
);
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic hold;
	logic next_hold;

	// ************************
	// count after all sources drop
	// ************************
	always_comb begin
		next_cnt = cnt;
		next_hold = hold;
		if (dl.any_active) begin
			next_cnt = '0;
			next_hold = 1'b1;
		end else if (hold) begin
			next_cnt = cnt + 1'b1;
			next_hold = (cnt + 1'b1) < dl.timeout_cycles;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= '0;
			hold <= 1'b1;
		end else begin
			cnt <= next_cnt;
			hold <= next_hold;
		end
	end

	assign dl.hold = hold;

	// ************************
	// checks
	// ************************
	a_hold_while_active: assert property (@(posedge clk) disable iff (rst)
		dl.any_active |=> hold) else $error("hold dropped while a source active");
	a_hold_release_time: assert property (@(posedge clk) disable iff (rst)
		$fell(hold) |-> $past(cnt) + 1'b1 == dl.timeout_cycles)
		else $error("hold released at wrong count");
endmodule : rsc_delay_counter

// ===== hw/rsc_reset_controller.sv
// reset source controller: merges five reset sources into one internal reset
// assumes raw monitor, pin and scan levels are asynchronous; watchdog inputs on clk
//
// What this block does
// - reset clears I/O; release starts reset vector
// - every source except the watchdog pulse resets I/O ports without clock
// - delay counter starts once all sources inactive
// - clock select fuses pick delay length
// - power-on active while supply below threshold
// - pin low longer than minimum width resets
// - watchdog expiry resets only when enabled
// - brown-out resets only when detection enabled
// - scan reset register one holds reset
// - watchdog gives one-cycle pulse, delay follows
// - sticky cause flags, power-on clears others
module rsc_reset_controller
	import rsc_pkg::*;
#(
	parameter int TOUT_SHORT_CYCLES = TOUT_SHORT_CYC,
	parameter int TOUT_LONG_CYCLES = TOUT_LONG_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// reset sources
	input wire logic supply_below_por,
	input wire logic reset_pin_n,
	input wire logic wdt_expired,
	input wire logic wdt_enable,
	input wire logic supply_below_bot,
	input wire logic brownout_detect_enable,
	input wire logic scan_reset_bit,
	// configuration
	input wire logic [FUSE_W-1:0] clock_select_fuses,
	// cause register write
	input wire logic cause_write,
	input wire logic [CAUSE_W-1:0] cause_write_data,
	// results
	output logic io_reset,
	output logic internal_reset,
	output logic reset_vector_fetch,
	output logic [CAUSE_W-1:0] reset_cause_register
);
	logic [NUM_SYNC-1:0] raw_src;
	logic [NUM_SYNC-1:0] sync_a;
	logic [NUM_SYNC-1:0] sync_b;
	logic por_active;
	logic pin_low;
	logic bot_active;
	logic scan_active;
	logic [PIN_CNT_W-1:0] pin_cnt;
	logic [PIN_CNT_W-1:0] next_pin_cnt;
	logic pin_active;
	logic wdt_pulse;
	logic next_wdt_pulse;
	logic any_active;
	logic [CAUSE_W-1:0] next_cause;
	logic [CAUSE_W-1:0] cause_set;
	logic hold_q;
	logic next_fetch;
	rsc_tout_type tout_sel;
	rsc_dly_if #(.CNT_W(DLY_CNT_W)) dl ();

	// ************************
	// immediate I/O reset
	// ************************
	// raw levels except the registered wdt_pulse and internal_reset, so those ports reset even with no clock running
	assign io_reset = supply_below_por | ~reset_pin_n | wdt_pulse
		| (supply_below_bot & brownout_detect_enable) | scan_reset_bit
		| internal_reset;

	// ************************
	// synchronisers
	// ************************
	assign raw_src = {scan_reset_bit, supply_below_bot, ~reset_pin_n, supply_below_por};

	generate
		for (genvar i = 0; i < NUM_SYNC; i++) begin : g_sync
			always_ff @(posedge clk) begin
				if (rst) begin
					sync_a[i] <= 1'b0;
					sync_b[i] <= 1'b0;
				end else begin
					sync_a[i] <= raw_src[i];
					sync_b[i] <= sync_a[i];
				end
			end
		end
	endgenerate

	assign por_active = sync_b[0];
	assign pin_low = sync_b[1];
	assign bot_active = sync_b[2] & brownout_detect_enable;
	assign scan_active = sync_b[3];

	// ************************
	// pin width filter
	// ************************
	always_comb begin
		next_pin_cnt = pin_cnt;
		if (!pin_low) begin
			next_pin_cnt = '0;
		end else if (pin_cnt != PIN_CNT_W'(PIN_MIN_CYCLES)) begin
			next_pin_cnt = pin_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pin_cnt <= '0;
		end else begin
			pin_cnt <= next_pin_cnt;
		end
	end

	assign pin_active = pin_low && (pin_cnt == PIN_CNT_W'(PIN_MIN_CYCLES));

	// ************************
	// watchdog pulse
	// ************************
	always_comb begin
		next_wdt_pulse = wdt_expired & wdt_enable & ~wdt_pulse;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wdt_pulse <= 1'b0;
		end else begin
			wdt_pulse <= next_wdt_pulse;
		end
	end

	// ************************
	// combined condition and delay
	// ************************
	assign any_active = por_active | pin_active | wdt_pulse | bot_active | scan_active;

	always_comb begin
		tout_sel = rsc_tout_type'(clock_select_fuses[FUSE_SEL_LSB +: FUSE_SEL_W]);
		case (tout_sel)
			RSC_TOUT_NONE: dl.timeout_cycles = DLY_CNT_W'(TOUT_NONE_CYC);
			RSC_TOUT_SHORT: dl.timeout_cycles = DLY_CNT_W'(TOUT_SHORT_CYCLES);
			RSC_TOUT_LONG: dl.timeout_cycles = DLY_CNT_W'(TOUT_LONG_CYCLES);
			default: dl.timeout_cycles = DLY_CNT_W'(TOUT_LONG_CYCLES);
		endcase
	end

	assign dl.any_active = any_active;
	assign internal_reset = dl.hold;

	rsc_delay_counter #(.CNT_W(DLY_CNT_W)) u_dly (
		.clk(clk),
		.rst(rst),
		.dl(dl.dly)
	);

	// ************************
	// reset vector start
	// ************************
	always_comb begin
		next_fetch = hold_q & ~internal_reset;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hold_q <= 1'b1;
			reset_vector_fetch <= 1'b0;
		end else begin
			hold_q <= internal_reset;
			reset_vector_fetch <= next_fetch;
		end
	end

	// ************************
	// cause flags
	// ************************
	always_comb begin
		cause_set = '0;
		cause_set[CAUSE_POR] = por_active;
		cause_set[CAUSE_PIN] = pin_active;
		cause_set[CAUSE_BOT] = bot_active;
		cause_set[CAUSE_WDT] = wdt_pulse;
		cause_set[CAUSE_SCAN] = scan_active;
		next_cause = reset_cause_register;
		if (cause_write) begin
			next_cause = next_cause & cause_write_data;
		end
		if (por_active) begin
			next_cause = next_cause & (CAUSE_W'(1) << CAUSE_POR);
		end
		next_cause = next_cause | cause_set;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reset_cause_register <= CAUSE_RESET;
		end else begin
			reset_cause_register <= next_cause;
		end
	end

	// ************************
	// checks
	// ************************
	sequence s_wdt_fire;
		wdt_expired && wdt_enable && !wdt_pulse;
	endsequence

	sequence s_wdt_one_cycle;
		wdt_pulse ##1 !wdt_pulse;
	endsequence

	a_wdt_pulse_once: assert property (@(posedge clk) disable iff (rst)
		s_wdt_fire |=> s_wdt_one_cycle) else $error("watchdog pulse not one cycle");
	a_wdt_needs_enable: assert property (@(posedge clk) disable iff (rst)
		!wdt_enable |=> !wdt_pulse) else $error("watchdog reset while disabled");
	a_pin_width: assert property (@(posedge clk) disable iff (rst)
		$rose(pin_active) |-> $past(pin_low, 75)) else $error("pin reset too short");
	a_bot_gated: assert property (@(posedge clk) disable iff (rst)
		!brownout_detect_enable |=> !$rose(reset_cause_register[CAUSE_BOT]))
		else $error("brown-out while disabled");
	a_io_reset_src: assert property (@(posedge clk) disable iff (rst)
		(!reset_pin_n || scan_reset_bit || supply_below_por) |-> io_reset)
		else $error("io reset missing");
	// a one-cycle time-out may drop the hold right after the first inactive cycle
	a_delay_after_src: assert property (@(posedge clk) disable iff (rst)
		any_active |=> internal_reset ##1 (internal_reset || tout_sel == RSC_TOUT_NONE))
		else $error("early release");
	a_fetch_on_release: assert property (@(posedge clk) disable iff (rst)
		$fell(internal_reset) |=> reset_vector_fetch ##1 !reset_vector_fetch)
		else $error("no reset vector start");
	a_por_clears: assert property (@(posedge clk) disable iff (rst)
		por_active |=> reset_cause_register[CAUSE_POR] && !reset_cause_register[CAUSE_PIN]
		|| $past(pin_active)) else $error("power-on did not clear flags");
	a_scan_holds: assert property (@(posedge clk) disable iff (rst)
		scan_active |=> internal_reset && reset_cause_register[CAUSE_SCAN])
		else $error("scan reset not held");
	a_por_holds: assert property (@(posedge clk) disable iff (rst)
		por_active |=> internal_reset) else $error("power-on reset not held");
endmodule : rsc_reset_controller

// ===== inc/rsc_dly_if.sv
// carrier between the controller and its delay counter
// assumes both ends share one clock
interface rsc_dly_if #(parameter int CNT_W = 22);
	logic any_active;
	logic [CNT_W-1:0] timeout_cycles;
	logic hold;
	modport ctrl (output any_active, output timeout_cycles, input hold);
	modport dly (input any_active, input timeout_cycles, output hold);
endinterface : rsc_dly_if

// ===== inc/rsc_pkg.sv
// package of constants for the reset source controller
// assumes a 50 MHz system clock
package rsc_pkg;
	// ************************
	// timing
	// ************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int PIN_MIN_NS = 1500;
	localparam int PIN_MIN_CYCLES = (PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PIN_CNT_W = 7;
	localparam int TOUT_SHORT_US = 4100;
	localparam int TOUT_LONG_US = 65000;
	localparam int TOUT_SHORT_CYC = TOUT_SHORT_US * 1000 / CLK_PERIOD_NS;
	localparam int TOUT_LONG_CYC = TOUT_LONG_US * 1000 / CLK_PERIOD_NS;
	localparam int TOUT_NONE_CYC = 1;
	localparam int DLY_CNT_W = 22;
	// ************************
	// fuse and cause fields
	// ************************
	localparam int FUSE_W = 4;
	localparam int FUSE_SEL_LSB = 0;
	localparam int FUSE_SEL_W = 2;
	localparam int CAUSE_W = 5;
	localparam int CAUSE_POR = 0;
	localparam int CAUSE_PIN = 1;
	localparam int CAUSE_BOT = 2;
	localparam int CAUSE_WDT = 3;
	localparam int CAUSE_SCAN = 4;
	localparam logic [CAUSE_W-1:0] CAUSE_RESET = 5'h00;
	localparam int NUM_SYNC = 4;
	typedef enum logic [1:0] {
		RSC_TOUT_NONE,
		RSC_TOUT_SHORT,
		RSC_TOUT_LONG,
		RSC_TOUT_LONG2
	} rsc_tout_type;
endpackage : rsc_pkg

// ===== tb/rsc_src_model.sv
// far side model: supply monitors, reset pin, watchdog and scan register
// assumes the bench calls its tasks; lines rest inactive between uses
module rsc_src_model (
	// clock
	input wire logic clk,
	// source levels
	output logic supply_below_por,
	output logic reset_pin_n,
	output logic wdt_expired,
	output logic supply_below_bot,
	output logic scan_reset_bit
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		{supply_below_por, wdt_expired, supply_below_bot, scan_reset_bit} = 4'h0;
		reset_pin_n = 1'b1;
	end
	// pin pulled up again after the low phase
	task automatic pin_low(input int n);
		@(posedge clk);
		reset_pin_n <= 1'b0;
		repeat (n) @(posedge clk);
		reset_pin_n <= 1'b1;
	endtask : pin_low
	task automatic level(input int w, input int n);
		@(posedge clk);
		case (w)
			0: supply_below_por <= 1'b1;
			1: supply_below_bot <= 1'b1;
			default: scan_reset_bit <= 1'b1;
		endcase
		repeat (n) @(posedge clk);
		{supply_below_por, supply_below_bot, scan_reset_bit} <= 3'h0;
	endtask : level
	task automatic wdt_kick();
		@(posedge clk);
		wdt_expired <= 1'b1;
		@(posedge clk);
		wdt_expired <= 1'b0;
	endtask : wdt_kick
endmodule : rsc_src_model

// ===== tb/tb_top.sv
// bench for the reset source controller
// assumes shortened delay counts of 20 and 40 cycles
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import rsc_pkg::*;
	localparam int SIM_SHORT = 20;
	localparam int SIM_LONG = 40;
	typedef struct {logic [3:0] fuse; logic en; int hi; logic [4:0] cause;} rsc_row_type;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wdt_enable = 1'b0;
	logic brownout_detect_enable = 1'b0;
	logic [FUSE_W-1:0] fuses = 4'h0;
	logic cause_write = 1'b0;
	logic [CAUSE_W-1:0] cause_write_data = 5'h00;
	logic por, pin_n, wdt, bot, scan, io_reset, internal_reset, fetch;
	logic [CAUSE_W-1:0] cause;
	int errors = 0;
	int checks = 0;
	int hi, vf;
	// hold lasts exactly the selected time-out, counted from the first quiet cycle
	rsc_row_type rows [5] = '{'{4'h0, 1'b1, TOUT_NONE_CYC, 5'h08},
		'{4'h1, 1'b1, SIM_SHORT, 5'h08}, '{4'h2, 1'b1, SIM_LONG, 5'h08},
		'{4'h3, 1'b1, SIM_LONG, 5'h08}, '{4'h1, 1'b0, 0, 5'h00}};
	always #10 clk = ~clk;
	rsc_reset_controller #(.TOUT_SHORT_CYCLES(SIM_SHORT), .TOUT_LONG_CYCLES(SIM_LONG))
		rsc_reset_controller_i (
		.clk(clk), .rst(rst), .supply_below_por(por), .reset_pin_n(pin_n),
		.wdt_expired(wdt), .wdt_enable(wdt_enable), .supply_below_bot(bot),
		.brownout_detect_enable(brownout_detect_enable), .scan_reset_bit(scan),
		.clock_select_fuses(fuses), .cause_write(cause_write),
		.cause_write_data(cause_write_data), .io_reset(io_reset),
		.internal_reset(internal_reset), .reset_vector_fetch(fetch),
		.reset_cause_register(cause));
	rsc_src_model rsc_src_model_i (.clk(clk), .supply_below_por(por), .reset_pin_n(pin_n),
		.wdt_expired(wdt), .supply_below_bot(bot), .scan_reset_bit(scan));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk
	// counts cycles of held reset and of vector fetch
	task automatic watch(input int n);
		hi = 0;
		vf = 0;
		repeat (n) begin
			@(negedge clk);
			hi += (internal_reset === 1'b1);
			vf += (fetch === 1'b1);
		end
	endtask : watch
	task automatic clear_cause(input logic [CAUSE_W-1:0] keep = 5'h00);
		@(posedge clk);
		cause_write <= 1'b1;
		cause_write_data <= keep;
		@(posedge clk);
		cause_write <= 1'b0;
		@(posedge clk);
	endtask : clear_cause
	task automatic close_out();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out
	initial begin
		#(5000 * 20);
		errors++;
		close_out();
	end
	initial begin
		repeat (3) @(negedge clk);
		chk("rst_internal", internal_reset, 1);
		chk("rst_io", io_reset, 1);
		chk("rst_cause", cause, 0);
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		watch(10);
		chk("rst_release", hi, TOUT_NONE_CYC);
		chk("rst_fetch", vf, 1);
		$display("reset test done");
		foreach (rows[i]) begin
			@(posedge clk);
			fuses <= rows[i].fuse;
			wdt_enable <= rows[i].en;
			clear_cause();
			rsc_src_model_i.wdt_kick();
			watch(60);
			chk("wdt_hold", hi, rows[i].hi);
			chk("wdt_fetch", vf, rows[i].hi > 0);
			chk("wdt_cause", cause, rows[i].cause);
			$display("row %0d done", i);
		end
		@(posedge clk);
		fuses <= 4'h0;
		brownout_detect_enable <= 1'b1;
		clear_cause();
		fork
			rsc_src_model_i.level(1, 10);
			begin
				@(posedge clk);
				#2;
				chk("bot_io_now", io_reset, 1);
			end
			watch(20);
		join
		chk("bot_hold", hi > 9, 1);
		chk("bot_cause", cause, 5'h04);
		@(posedge clk);
		brownout_detect_enable <= 1'b0;
		clear_cause();
		fork
			rsc_src_model_i.level(1, 10);
			watch(20);
		join
		chk("bot_off", hi, 0);
		chk("bot_off_cause", cause, 5'h00);
		fork
			rsc_src_model_i.pin_low(50);
			watch(80);
		join
		chk("pin_short", hi, 0);
		fork
			rsc_src_model_i.pin_low(100);
			watch(140);
		join
		chk("pin_long", hi > 20, 1);
		chk("pin_cause", cause, 5'h02);
		fork
			rsc_src_model_i.level(2, 60);
			watch(70);
		join
		chk("scan_hold", hi > 55, 1);
		chk("scan_fetch", vf, 1);
		fork
			rsc_src_model_i.level(0, 10);
			watch(30);
		join
		chk("por_hold", hi > 9, 1);
		chk("por_cause", cause, 5'h01);
		clear_cause(5'h01);
		@(negedge clk);
		chk("por_keep", cause, 5'h01);
		clear_cause();
		@(negedge clk);
		chk("por_clear", cause, 0);
		$display("source tests done");
		close_out();
	end
endmodule : tb_top
